// ### include/afe_i2c_pkg.sv
// Shared constants for the sensor front-end serial configuration link.
package afe_i2c_pkg;
   // Clock rate and derived timing.
   localparam int CLK_MHZ = 250;
   localparam int TIMEOUT_US = 25000;
   localparam int TIMEOUT_CYCLES = TIMEOUT_US * CLK_MHZ;
   localparam int SCL_KHZ = 100;
   localparam int QTR_CYCLES = (CLK_MHZ * 1000) / (4 * SCL_KHZ);
   // Fixed bus address of the front end.
   localparam logic [6:0] SLAVE_ADDR = 7'h48;
   // Front-end register pointers.
   localparam logic [7:0] PTR_STATUS = 8'h00;
   localparam logic [7:0] PTR_LOCK = 8'h01;
   localparam logic [7:0] PTR_GAIN = 8'h10;
   localparam logic [7:0] PTR_REF = 8'h11;
   localparam logic [7:0] PTR_MODE = 8'h12;
   // Front-end reset values.
   localparam logic [7:0] RST_LOCK = 8'h01;
   localparam logic [7:0] RST_GAIN = 8'h03;
   localparam logic [7:0] RST_REF = 8'h20;
   localparam logic [7:0] RST_MODE = 8'h00;
   // Field positions.
   localparam int GAIN_LSB = 2;
   localparam int REF_SRC_BIT = 7;
   localparam int INT_Z_LSB = 5;
   localparam int FET_BIT = 7;
   localparam logic [2:0] GAIN_EXTERNAL = 3'h0;
   localparam logic [2:0] MODE_DEEP_SLEEP = 3'h0;
   localparam logic [2:0] MODE_TIA_OFF = 3'h6;
   // Controller register offsets on APB.
   localparam logic [7:0] APB_CMD = 8'h00;
   localparam logic [7:0] APB_STAT = 8'h04;
   localparam logic [7:0] APB_SEL = 8'h08;
   localparam int CMD_GO = 0;
   localparam int CMD_READ = 1;
   localparam int STAT_BUSY = 0;
   localparam int STAT_DONE = 1;
   localparam int STAT_NACK = 2;
endpackage

// ### include/i2c_link_if.sv
// Two-wire link with module select joining the controller and the front end.
`timescale 1ns/1ps
interface i2c_link_if;
   logic host_scl_o;
   logic host_scl_oe_n;
   logic host_sda_o;
   logic host_sda_oe_n;
   logic dev_sda_o;
   logic dev_sda_oe_n;
   logic module_select_n;
   logic scl;
   logic sda;
   // Pull-ups hold each line high unless an enabled driver pulls it low.
   assign scl = !(!host_scl_oe_n && !host_scl_o);
   assign sda = !((!host_sda_oe_n && !host_sda_o) || (!dev_sda_oe_n && !dev_sda_o));
   modport device (input scl, input sda, input module_select_n, output dev_sda_o, output dev_sda_oe_n);
   modport host (input sda, output host_scl_o, output host_scl_oe_n, output host_sda_o, output host_sda_oe_n,
                 output module_select_n);
endinterface

// ### design/sensor_afe_i2c_config_slave.sv
// Front-end end of the link: serial slave, configuration registers and stuck-line timeout.
`timescale 1ns/1ps
module sensor_afe_i2c_config_slave
   import afe_i2c_pkg::*;
#(
   parameter int TIMEOUT_CYC = TIMEOUT_CYCLES
) (
   input wire logic pclk, // System clock.
   input wire logic presetn, // Asynchronous reset, active low.
   i2c_link_if.device link, // Serial link pins.
   input wire logic init_done, // Power-on initialisation finished.
   output logic [2:0] gain_sel, // Feedback resistor code.
   output logic ext_gain_sel, // External resistor across the gain nodes.
   output logic ref_source_ext, // Zero level from external reference.
   output logic [1:0] int_zero_sel, // Zero level divider tap.
   output logic [3:0] diag_step, // Diagnostic step code.
   output logic fet_short, // Shorting switch enable.
   output logic [2:0] op_mode, // Operating mode code.
   output logic tia_power_down, // Transimpedance amplifier off.
   output logic load_switch_en, // Dummy load in place of the amplifier.
   output logic counter_drive_amp_en // Counter electrode amplifier on.
);
   typedef enum {D_IDLE, D_ADDR, D_ADDR_ACK, D_PTR, D_PTR_ACK, D_DATA, D_DATA_ACK, D_RD, D_RD_ACK} dev_state_t;

   dev_state_t state_r;
   logic [3:0] meta_r;
   logic [3:0] sync_r;
   logic scl_q_r;
   logic sda_q_r;
   logic scl;
   logic sda;
   logic msel_n;
   logic ready;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   logic [3:0] cnt_r;
   logic [7:0] rx_r;
   logic [7:0] tx_r;
   logic sda_low_r;
   logic rw_r;
   logic mst_ack_r;
   logic [7:0] ptr_r;
   logic [7:0] lock_r;
   logic [7:0] gain_r;
   logic [7:0] ref_r;
   logic [7:0] mode_r;
   logic [22:0] scl_low_cnt_r;
   logic [22:0] sda_hold_cnt_r;
   logic timeout;
   logic wr_stb;
   logic [7:0] rd_byte;
   logic meta_init_seen_r;

   // Every pin input and the ready level pass two flops before use.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_r <= 4'h7;
         sync_r <= 4'h7;
      end else begin
         meta_r <= {init_done, link.module_select_n, link.sda, link.scl};
         sync_r <= meta_r;
      end
   end

   // Lines reset high as the pull-ups leave them; the ready level resets low so no false ready follows reset.
   assign scl = sync_r[0];
   assign sda = sync_r[1];
   assign msel_n = sync_r[2];
   assign ready = sync_r[3] && meta_init_seen_r;

   // Ready only counts after one clean sample cycle past reset, so it reads zero first.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_init_seen_r <= 1'b0;
      end else begin
         meta_init_seen_r <= 1'b1;
      end
   end

   // Previous line levels for edge and condition detection.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scl_q_r <= 1'b1;
         sda_q_r <= 1'b1;
      end else begin
         scl_q_r <= scl;
         sda_q_r <= sda;
      end
   end

   assign scl_rise = scl && !scl_q_r;
   assign scl_fall = !scl && scl_q_r;
   assign start_det = scl && scl_q_r && sda_q_r && !sda && !msel_n;
   assign stop_det = scl && scl_q_r && !sda_q_r && sda;

   // Stuck-line counters restart once the clock is high again, or once the device stops pulling data, and on a timeout.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scl_low_cnt_r <= '0;
         sda_hold_cnt_r <= '0;
      end else begin
         scl_low_cnt_r <= scl ? '0 : (timeout ? '0 : scl_low_cnt_r + 23'h1);
         sda_hold_cnt_r <= (!sda_low_r || timeout) ? '0 : sda_hold_cnt_r + 23'h1;
      end
   end

   assign timeout = (scl_low_cnt_r == 23'(TIMEOUT_CYC - 1)) ||
                    (sda_hold_cnt_r == 23'(TIMEOUT_CYC - 1));

   // Read mux; reserved pointers read as zero.
   always_comb begin
      unique case (ptr_r)
         PTR_STATUS: rd_byte = {7'h00, ready};
         PTR_LOCK: rd_byte = lock_r;
         PTR_GAIN: rd_byte = gain_r;
         PTR_REF: rd_byte = ref_r;
         PTR_MODE: rd_byte = mode_r;
         default: rd_byte = 8'h00;
      endcase
   end

   // Protocol engine: bits are taken on the clock rise and changed after the clock fall.
   // A deselect, a stop or a timeout drops back to idle and lets go of the data line at once.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= D_IDLE;
         cnt_r <= 4'h0;
         rx_r <= 8'h00;
         tx_r <= 8'h00;
         sda_low_r <= 1'b0;
         rw_r <= 1'b0;
         mst_ack_r <= 1'b0;
         ptr_r <= 8'h00;
      end else if (msel_n || timeout || stop_det) begin
         state_r <= D_IDLE;
         sda_low_r <= 1'b0;
      end else if (start_det) begin
         state_r <= D_ADDR;
         cnt_r <= 4'h0;
         sda_low_r <= 1'b0;
      end else if (scl_rise) begin
         unique case (state_r)
            D_ADDR, D_PTR, D_DATA: begin
               rx_r <= {rx_r[6:0], sda};
               cnt_r <= cnt_r + 4'h1;
            end
            D_RD: cnt_r <= cnt_r + 4'h1;
            D_RD_ACK: mst_ack_r <= !sda;
            default: ;
         endcase
      end else if (scl_fall) begin
         unique case (state_r)
            D_ADDR: begin
               if (cnt_r == 4'h8) begin
                  if (rx_r[7:1] == SLAVE_ADDR) begin
                     state_r <= D_ADDR_ACK;
                     sda_low_r <= 1'b1;
                     rw_r <= rx_r[0];
                  end else begin
                     state_r <= D_IDLE;
                  end
               end
            end
            D_ADDR_ACK: begin
               cnt_r <= 4'h0;
               if (rw_r) begin
                  state_r <= D_RD;
                  tx_r <= rd_byte;
                  sda_low_r <= !rd_byte[7];
               end else begin
                  state_r <= D_PTR;
                  sda_low_r <= 1'b0;
               end
            end
            D_PTR: begin
               if (cnt_r == 4'h8) begin
                  ptr_r <= rx_r;
                  state_r <= D_PTR_ACK;
                  sda_low_r <= 1'b1;
               end
            end
            D_PTR_ACK, D_DATA_ACK: begin
               state_r <= D_DATA;
               cnt_r <= 4'h0;
               sda_low_r <= 1'b0;
            end
            D_DATA: begin
               if (cnt_r == 4'h8) begin
                  state_r <= D_DATA_ACK;
                  sda_low_r <= 1'b1;
               end
            end
            D_RD: begin
               if (cnt_r == 4'h8) begin
                  state_r <= D_RD_ACK;
                  sda_low_r <= 1'b0;
               end else begin
                  sda_low_r <= !tx_r[6];
                  tx_r <= {tx_r[6:0], 1'b0};
               end
            end
            D_RD_ACK: begin
               // Further reads after an acknowledge repeat the same register.
               if (mst_ack_r) begin
                  state_r <= D_RD;
                  cnt_r <= 4'h0;
                  tx_r <= rd_byte;
                  sda_low_r <= !rd_byte[7];
               end else begin
                  state_r <= D_IDLE;
               end
            end
            default: ;
         endcase
      end
   end

   // A data byte lands in the register only once initialisation is complete.
   assign wr_stb = scl_fall && (state_r == D_DATA) && (cnt_r == 4'h8) && ready && !msel_n && !timeout &&
                   !stop_det && !start_det;

   // Lock bit is writable whatever its own value, once initialisation is complete.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lock_r <= RST_LOCK;
      end else if (wr_stb && ptr_r == PTR_LOCK) begin
         lock_r <= rx_r;
      end
   end

   // Gain and reference follow the lock; a timeout never touches them.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gain_r <= RST_GAIN;
         ref_r <= RST_REF;
      end else if (wr_stb && !lock_r[0]) begin
         if (ptr_r == PTR_GAIN) begin
            gain_r <= rx_r;
         end
         if (ptr_r == PTR_REF) begin
            ref_r <= rx_r;
         end
      end
   end

   // Mode register is not lockable.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_r <= RST_MODE;
      end else if (wr_stb && ptr_r == PTR_MODE) begin
         mode_r <= rx_r;
      end
   end

   // Open-drain data: the output is always zero and the enable decides.
   assign link.dev_sda_o = 1'b0;
   assign link.dev_sda_oe_n = !sda_low_r;

   // Analog controls straight from the stored fields.
   assign gain_sel = gain_r[GAIN_LSB +: 3];
   assign ext_gain_sel = (gain_sel == GAIN_EXTERNAL);
   assign ref_source_ext = ref_r[REF_SRC_BIT];
   assign int_zero_sel = ref_r[INT_Z_LSB +: 2];
   assign diag_step = ref_r[3:0];
   assign fet_short = mode_r[FET_BIT];
   assign op_mode = mode_r[2:0];
   assign tia_power_down = (op_mode == MODE_TIA_OFF) || (op_mode == MODE_DEEP_SLEEP);
   assign load_switch_en = (op_mode == MODE_TIA_OFF);
   assign counter_drive_amp_en = (op_mode != MODE_DEEP_SLEEP);
endmodule

// ### design/i2c_cfg_master.sv
// Controller end of the link: APB command registers driving a two-wire master.
`timescale 1ns/1ps
module i2c_cfg_master
   import afe_i2c_pkg::*;
#(
   parameter int QTR_CYC = QTR_CYCLES
) (
   input wire logic pclk, // System clock.
   input wire logic presetn, // Asynchronous reset, active low.
   input wire logic psel, // APB select.
   input wire logic penable, // APB enable.
   input wire logic pwrite, // APB direction.
   input wire logic [7:0] paddr, // APB byte address.
   input wire logic [31:0] pwdata, // APB write data.
   output logic [31:0] prdata, // APB read data.
   output logic pready, // APB ready.
   output logic pslverr, // APB error on unmapped address.
   i2c_link_if.host link // Serial link pins.
);
   typedef enum {H_IDLE, H_START, H_BIT, H_STOP} host_state_t;

   host_state_t state_r;
   logic [9:0] div_r;
   logic tick;
   logic [1:0] phase_r;
   logic [2:0] step_r;
   logic [3:0] bit_r;
   logic [8:0] tx_r;
   logic [8:0] rx_r;
   logic scl_low_r;
   logic sda_low_r;
   logic [1:0] sda_sync_r;
   logic rd_r;
   logic [7:0] ptr_r;
   logic [7:0] wdat_r;
   logic [7:0] rdata_r;
   logic done_r;
   logic nack_r;
   logic sel_r;
   logic wr_acc;
   logic go;
   logic fin;
   logic [8:0] next_byte;

   // The slave answers every access in its first access cycle.
   assign pready = 1'b1;
   assign wr_acc = psel && penable && pwrite;
   assign pslverr = psel && penable && !(paddr == APB_CMD || paddr == APB_STAT || paddr == APB_SEL);
   assign go = wr_acc && paddr == APB_CMD && pwdata[CMD_GO] && state_r == H_IDLE;
   assign fin = tick && state_r == H_STOP && phase_r == 2'h3;

   always_comb begin
      unique case (paddr)
         APB_CMD: prdata = {8'h00, wdat_r, ptr_r, 6'h00, rd_r, 1'b0};
         APB_STAT: prdata = {16'h0000, rdata_r, 5'h00, nack_r, done_r, state_r != H_IDLE};
         APB_SEL: prdata = {31'h0, sel_r};
         default: prdata = 32'h0;
      endcase
   end

   // Command fields are latched when a transfer is launched.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_r <= 1'b0;
         ptr_r <= 8'h00;
         wdat_r <= 8'h00;
      end else if (go) begin
         rd_r <= pwdata[CMD_READ];
         ptr_r <= pwdata[15:8];
         wdat_r <= pwdata[23:16];
      end
   end

   // Select is software's; it must stay asserted across the whole transfer.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel_r <= 1'b0;
      end else if (wr_acc && paddr == APB_SEL) begin
         sel_r <= pwdata[0];
      end
   end

   // Done is sticky; a finish in the clearing cycle wins over the clear.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done_r <= 1'b0;
      end else if (fin) begin
         done_r <= 1'b1;
      end else if (wr_acc && paddr == APB_STAT && pwdata[STAT_DONE]) begin
         done_r <= 1'b0;
      end
   end

   // Quarter-bit timebase sets the 100 kHz bit rate.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_r <= 10'h0;
      end else begin
         div_r <= (tick || state_r == H_IDLE) ? 10'h0 : div_r + 10'h1;
      end
   end

   assign tick = (div_r == 10'(QTR_CYC - 1));

   // Data line sampled through two flops.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sda_sync_r <= 2'h3;
      end else begin
         sda_sync_r <= {sda_sync_r[0], link.sda};
      end
   end

   // Byte for each step; the ninth bit stays released for the slave's acknowledge.
   always_comb begin
      unique case (step_r)
         3'h0: next_byte = {SLAVE_ADDR, 1'b0, 1'b1};
         3'h1: next_byte = {ptr_r, 1'b1};
         3'h2: next_byte = {wdat_r, 1'b1};
         3'h3: next_byte = {SLAVE_ADDR, 1'b1, 1'b1};
         default: next_byte = 9'h1ff;
      endcase
   end

   // Bit engine: four quarters per bit, data changes only while the clock is low, except for the start and stop conditions.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= H_IDLE;
         phase_r <= 2'h0;
         step_r <= 3'h0;
         bit_r <= 4'h0;
         tx_r <= 9'h1ff;
         rx_r <= 9'h000;
         scl_low_r <= 1'b0;
         sda_low_r <= 1'b0;
         nack_r <= 1'b0;
         rdata_r <= 8'h00;
      end else if (go) begin
         state_r <= H_START;
         phase_r <= 2'h0;
         step_r <= 3'h0;
         nack_r <= 1'b0;
      end else if (tick) begin
         phase_r <= phase_r + 2'h1;
         unique case (state_r)
            H_START: begin
               unique case (phase_r)
                  // Data is released while the clock is low so a repeated start does not first make a stop.
                  2'h0: sda_low_r <= 1'b0;
                  2'h1: scl_low_r <= 1'b0;
                  2'h2: sda_low_r <= 1'b1;
                  2'h3: begin
                     scl_low_r <= 1'b1;
                     state_r <= H_BIT;
                     tx_r <= next_byte;
                     bit_r <= 4'h0;
                  end
               endcase
            end
            H_BIT: begin
               unique case (phase_r)
                  2'h0: sda_low_r <= !tx_r[8];
                  2'h1: scl_low_r <= 1'b0;
                  2'h2: rx_r <= {rx_r[7:0], sda_sync_r[1]};
                  2'h3: begin
                     scl_low_r <= 1'b1;
                     tx_r <= {tx_r[7:0], 1'b1};
                     bit_r <= bit_r + 4'h1;
                     if (bit_r == 4'h8) begin
                        bit_r <= 4'h0;
                        if (step_r == 3'h4) begin
                           rdata_r <= rx_r[8:1];
                           state_r <= H_STOP;
                        end else if (rx_r[0]) begin
                           nack_r <= 1'b1;
                           state_r <= H_STOP;
                        end else if (!rd_r && step_r == 3'h2) begin
                           state_r <= H_STOP;
                        end else if (rd_r && step_r == 3'h1) begin
                           step_r <= 3'h3;
                           state_r <= H_START;
                        end else begin
                           step_r <= step_r + 3'h1;
                           tx_r <= next_byte_after(step_r);
                        end
                     end
                  end
               endcase
            end
            H_STOP: begin
               unique case (phase_r)
                  2'h0: sda_low_r <= 1'b1;
                  2'h1: scl_low_r <= 1'b0;
                  2'h2: sda_low_r <= 1'b0;
                  2'h3: state_r <= H_IDLE;
               endcase
            end
            default: ;
         endcase
      end
   end

   // Byte for the step that follows the given one.
   function automatic logic [8:0] next_byte_after(input logic [2:0] s);
      unique case (s)
         3'h0: next_byte_after = {ptr_r, 1'b1};
         3'h1: next_byte_after = {wdat_r, 1'b1};
         default: next_byte_after = 9'h1ff;
      endcase
   endfunction

   // Open-drain outputs: value zero, enable low while pulling down.
   assign link.host_scl_o = 1'b0;
   assign link.host_scl_oe_n = !scl_low_r;
   assign link.host_sda_o = 1'b0;
   assign link.host_sda_oe_n = !sda_low_r;
   assign link.module_select_n = !sel_r;
endmodule

// ### verif/afe_link_props.sv
// Link checker: open-drain levels, bus timing and quiet rules.
`timescale 1ns/1ps
module afe_link_props #(
   parameter int TO = 2000,
   parameter int QTR = 8
) (
   input wire logic pclk, // Clock.
   input wire logic presetn, // Reset.
   input wire logic scl, // Clock line.
   input wire logic sda, // Data line.
   input wire logic module_select_n, // Select.
   input wire logic dev_sda_o, // Device data.
   input wire logic dev_sda_oe_n, // Device pull.
   input wire logic host_scl_o, // Host clock.
   input wire logic host_scl_oe_n, // Host clock pull.
   input wire logic host_sda_o, // Host data.
   input wire logic host_sda_oe_n // Host data pull.
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [15:0] dev_cnt_r, per_r, hi_r;
   // Length of the device's current pull, which must never outlive the timeout.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) dev_cnt_r <= 16'h0000;
      else dev_cnt_r <= dev_sda_oe_n ? 16'h0000 : dev_cnt_r + 16'h0001;
   end
   // Cycles since the last clock rise; saturates so idle gaps never wrap.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) per_r <= 16'hffff;
      else if ($rose(scl)) per_r <= 16'h0000;
      else if (per_r != 16'hffff) per_r <= per_r + 16'h0001;
   end
   // Length of the current clock high phase.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) hi_r <= 16'h0000;
      else hi_r <= scl ? hi_r + 16'h0001 : 16'h0000;
   end
   a_dev_drive_low: assert property (!dev_sda_oe_n |-> !dev_sda_o && !sda)
      else $error("device drives data high");
   a_host_scl_low: assert property (!host_scl_oe_n |-> !host_scl_o && !scl)
      else $error("host drives clock high");
   a_host_sda_low: assert property (!host_sda_oe_n |-> !host_sda_o && !sda)
      else $error("host drives data high");
   a_desel_quiet: assert property (module_select_n [*5] |-> dev_sda_oe_n)
      else $error("deselected device pulls data");
   a_pull_bounded: assert property (dev_cnt_r <= 16'(TO + 4))
      else $error("device holds data past timeout");
   a_stable_while_high: assert property (scl && $past(scl) && !module_select_n |-> $stable(dev_sda_oe_n))
      else $error("device data moves while clock high");
   a_clock_period: assert property ($rose(scl) |-> per_r >= 16'(4 * QTR - 1))
      else $error("clock period too short");
   a_clock_high_time: assert property ($fell(scl) |-> hi_r >= 16'(2 * QTR - 1))
      else $error("clock high time too short");
   a_select_at_idle: assert property ($changed(module_select_n) |-> scl && sda)
      else $error("select moved during a transfer");
endmodule

// ### verif/sensor_afe_i2c_config_slave_test.sv
// Bench joining the controller and the front end over the link.
`timescale 1ns/1ps
module sensor_afe_i2c_config_slave_test;
   import afe_i2c_pkg::*;
   localparam int TO = 2000;
   localparam int QTR = 8;
   logic pclk = 1'b0, presetn = 1'b0, init_done = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00, v;
   logic [31:0] pwdata = 32'h0, prdata, rd, s;
   logic pready, pslverr, e, ext_gain_sel, ref_source_ext, fet_short, tia_power_down, load_switch_en;
   logic counter_drive_amp_en;
   logic [2:0] gain_sel, op_mode;
   logic [1:0] int_zero_sel;
   logic [3:0] diag_step;
   int miscompares = 0, cmp_count = 0, seed = 52, i;
   i2c_link_if i2c_link_if_inst ();
   i2c_cfg_master #(.QTR_CYC(QTR)) i2c_cfg_master_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .link(i2c_link_if_inst));
   sensor_afe_i2c_config_slave #(.TIMEOUT_CYC(TO)) sensor_afe_i2c_config_slave_inst (.pclk(pclk),
      .presetn(presetn), .link(i2c_link_if_inst), .init_done(init_done), .gain_sel(gain_sel),
      .ext_gain_sel(ext_gain_sel), .ref_source_ext(ref_source_ext), .int_zero_sel(int_zero_sel),
      .diag_step(diag_step), .fet_short(fet_short), .op_mode(op_mode), .tia_power_down(tia_power_down),
      .load_switch_en(load_switch_en), .counter_drive_amp_en(counter_drive_amp_en));
   afe_link_props #(.TO(TO), .QTR(QTR)) afe_link_props_inst (.pclk(pclk), .presetn(presetn),
      .scl(i2c_link_if_inst.scl), .sda(i2c_link_if_inst.sda), .module_select_n(i2c_link_if_inst.module_select_n),
      .dev_sda_o(i2c_link_if_inst.dev_sda_o), .dev_sda_oe_n(i2c_link_if_inst.dev_sda_oe_n),
      .host_scl_o(i2c_link_if_inst.host_scl_o), .host_scl_oe_n(i2c_link_if_inst.host_scl_oe_n),
      .host_sda_o(i2c_link_if_inst.host_sda_o), .host_sda_oe_n(i2c_link_if_inst.host_sda_oe_n));
   // Free-running 250 MHz clock.
   initial forever #2 pclk = ~pclk;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One APB transfer; the request is held until pready is seen at an edge.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      penable <= 1'b0;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // One link transaction: start it, poll until done, keep the status, clear done.
   task automatic xfer(input logic r, input logic [7:0] p, input logic [7:0] d);
      apb(1'b1, APB_CMD, {8'h00, d, p, 6'h00, r, 1'b1});
      rd = 32'h0;
      while (rd[STAT_DONE] !== 1'b1) apb(1'b0, APB_STAT, 32'h0);
      s = rd;
      apb(1'b1, APB_STAT, 32'h2);
   endtask
   task automatic results();
      if (miscompares == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // A hang anywhere ends the run as a failure.
   initial begin
      repeat (100000) @(posedge pclk);
      miscompares++;
      results();
   end
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk(32'({gain_sel, ext_gain_sel, ref_source_ext, int_zero_sel, diag_step, fet_short, op_mode,
         tia_power_down, load_switch_en, counter_drive_amp_en}), 32'({RST_GAIN[4:2], RST_GAIN[4:2] == 3'h0,
         RST_REF[7], RST_REF[6:5], RST_REF[3:0], RST_MODE[7], RST_MODE[2:0], 3'b100}));
      apb(1'b1, APB_SEL, 32'h1);
      apb(1'b0, APB_SEL, 32'h0);
      chk(rd, 32'h1);
      xfer(1'b1, PTR_STATUS, 8'h00);
      chk(32'(s[STAT_NACK]), 32'h0);
      chk(32'(s[8]), 32'h0);
      xfer(1'b0, PTR_LOCK, 8'h00);
      init_done <= 1'b1;
      xfer(1'b1, PTR_STATUS, 8'h00);
      chk(32'(s[8]), 32'h1);
      xfer(1'b1, PTR_LOCK, 8'h00);
      chk(32'(s[8]), 32'(RST_LOCK[0]));
      xfer(1'b0, PTR_GAIN, 8'h1c);
      chk(32'(gain_sel), 32'(RST_GAIN[4:2]));
      xfer(1'b0, PTR_LOCK, 8'h00);
      // Every gain code, each read back through a pointer-then-read transaction.
      for (i = 0; i < 8; i++) begin
         xfer(1'b0, PTR_GAIN, {3'h0, 3'(i), 2'h0});
         chk(32'({ext_gain_sel, gain_sel}), 32'({i == 0, 3'(i)}));
         xfer(1'b1, PTR_GAIN, 8'h00);
         chk(32'(s[12:10]), 32'(i));
      end
      // Zero-level taps 0 to 2 with random source and diagnostic step.
      for (i = 0; i < 3; i++) begin
         v = {1'($random(seed)), 2'(i), 1'b0, 4'($random(seed))};
         xfer(1'b0, PTR_REF, v);
         chk(32'({ref_source_ext, int_zero_sel, diag_step}), 32'({v[7:5], v[3:0]}));
      end
      // Every operating mode with a random shorting switch.
      for (i = 0; i < 8; i++) begin
         v = {1'($random(seed)), 4'h0, 3'(i)};
         xfer(1'b0, PTR_MODE, v);
         chk(32'({fet_short, op_mode}), 32'({v[7], 3'(i)}));
         chk(32'({tia_power_down, load_switch_en, counter_drive_amp_en}),
            32'({i == 0 || i == 6, i == 6, i != 0}));
      end
      chk(32'(counter_drive_amp_en), 32'h1);
      xfer(1'b0, 8'h05, 8'h5a);
      xfer(1'b1, 8'h05, 8'h00);
      chk(32'(s[15:8]), 32'h0);
      apb(1'b1, APB_SEL, 32'h0);
      xfer(1'b0, PTR_GAIN, 8'h04);
      chk(32'(s[STAT_NACK]), 32'h1);
      chk(32'(gain_sel), 32'h7);
      apb(1'b0, 8'h0c, 32'h0);
      chk({e, rd[30:0]}, 32'h80000000);
      results();
   end
endmodule
